/* shared/ptec_consts.vh */
// Constants shared by the playback trigger and event control block.
`ifndef PTEC_CONSTS_VH
`define PTEC_CONSTS_VH

// Register byte offsets.
`define PTEC_ADR_CTRL 8'h00
`define PTEC_ADR_STATUS 8'h04
`define PTEC_ADR_REPEAT 8'h08
`define PTEC_ADR_GPO 8'h0c
`define PTEC_ADR_DSEL 8'h10
`define PTEC_ADR_INDEX 8'h14
`define PTEC_ADR_LAST 8'h18

// Control register fields.
`define PTEC_CTRL_MODE_LSB 0
`define PTEC_CTRL_MODE_MSB 1
`define PTEC_CTRL_EXT 2
`define PTEC_CTRL_TPOL 3
`define PTEC_CTRL_EPOL 4
`define PTEC_CTRL_TOUT 5
`define PTEC_CTRL_PDIR 6
`define PTEC_CTRL_RUN 7
`define PTEC_CTRL_RST 32'h00000000

// Run modes.
`define PTEC_MODE_CONT 2'h0
`define PTEC_MODE_TRIG 2'h1
`define PTEC_MODE_GATE 2'h2

// Repeat register fields.
`define PTEC_REP_CNT_MSB 15
`define PTEC_REP_UNTIL 31
`define PTEC_REP_RST 32'h00000001

// Status register fields.
`define PTEC_STAT_DNEW 0
`define PTEC_STAT_PLAY 1
`define PTEC_STAT_TLVL 2
`define PTEC_STAT_TOUT 3
`define PTEC_STAT_ST_LSB 4

// Port layout when used as dynamic control input.
`define PTEC_SEL_W 24
`define PTEC_HALF_W 12
`define PTEC_PORT_W 14
`define PTEC_PIN_HALF 12
`define PTEC_PIN_LOAD 13

// Trigger output pulse width in sample clock cycles.
`define PTEC_TRIG_PULSE_CYC 11'd1280

`endif

/* hdl/ptec_edge.v */
// Polarity, two-stage synchroniser and rising edge detect per input line.
`timescale 1ns/10ps
`default_nettype none

module ptec_edge #(
  parameter W = 1
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Lines.
  input wire [W-1:0] pin_i,
  input wire [W-1:0] inv_i,
  output reg [W-1:0] level_o,
  output reg [W-1:0] rise_o
);

  reg [W-1:0] meta;
  reg [W-1:0] sync;

  // Polarity is applied ahead of the synchroniser so the active edge
  // is always a rising one downstream.
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= {W{1'b0}};
      sync <= {W{1'b0}};
      level_o <= {W{1'b0}};
      rise_o <= {W{1'b0}};
    end else begin
      meta <= pin_i ^ inv_i;
      sync <= meta;
      level_o <= sync;
      rise_o <= sync & ~level_o;
    end
  end

endmodule // ptec_edge

`default_nettype wire

/* hdl/ptec_top.v */
// Trigger, gate, event, trigger output and parallel port control.
//
// Summary of operation
// - The trigger/gate input starts or gates playback per run mode.
// - This trigger/gate input drives only this block's play output.
// - Trigger and event inputs each have a selectable polarity.
// - An active event advances the sequencer to the next entry.
// - The event step is one broadcast output for all channels.
// - Trigger output and event input share a pin, one at a time.
// - An enabled trigger output pulse lasts 1280 clock cycles.
// - The parallel port is set as input or output by software.
// - As input the port selects the sequence entry for all channels.
// - Select and half-select lines are taken on the load rise.
// - Two halves build a 24-bit selection value.
// - As output the port drives 14 software-set lines.
// - Each entry repeats a set count or until an event.
// - Extended gated mode plays only while the gate is high.
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ptec_consts.vh"

module ptec_top (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Trigger/gate input.
  input wire trig_pin_i,
  // Shared event input and trigger output pin.
  input wire evt_pin_i,
  output reg evt_pin_o,
  output reg evt_pin_oe_o,
  // Parallel control port.
  input wire [`PTEC_PORT_W-1:0] port_i,
  output reg [`PTEC_PORT_W-1:0] port_o,
  output reg [`PTEC_PORT_W-1:0] port_oe_o,
  // Waveform engine side.
  input wire seg_end_i,
  output reg play_o,
  output reg step_o,
  output reg [`PTEC_SEL_W-1:0] index_o
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_ARM = 4'b0010;
  localparam ST_PLAY = 4'b0100;
  localparam ST_GATE = 4'b1000;

  // Byte-lane merge for Wishbone writes.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] val;
    input [3:0] sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = val[i*8 +: 8];
        end
      end
    end
  endfunction

  reg [31:0] ctrl;
  reg [31:0] rep;
  reg [`PTEC_PORT_W-1:0] gpo;
  reg [`PTEC_SEL_W-1:0] last;
  reg [`PTEC_SEL_W-1:0] dsel;
  reg [`PTEC_HALF_W-1:0] dlow;
  reg dnew;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [15:0] rep_cnt;
  reg [10:0] tcnt;
  reg [31:0] next_dat;

  wire trig_lvl;
  wire trig_rise;
  wire evt_rise;
  wire [`PTEC_PORT_W-1:0] port_lvl;
  wire [`PTEC_PORT_W-1:0] port_rise;

  wire [1:0] mode = ctrl[`PTEC_CTRL_MODE_MSB:`PTEC_CTRL_MODE_LSB];
  wire ext = ctrl[`PTEC_CTRL_EXT];
  wire run = ctrl[`PTEC_CTRL_RUN];
  wire tout_en = ctrl[`PTEC_CTRL_TOUT];
  wire port_out = ctrl[`PTEC_CTRL_PDIR];
  wire until_evt = rep[`PTEC_REP_UNTIL];
  wire [15:0] rep_num = rep[`PTEC_REP_CNT_MSB:0];

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;
  // Lane-merged write values for the registers narrower than a word.
  wire [31:0] gpo_m = merge({18'h00000, gpo}, wb_dat_i, wb_sel_i);
  wire [31:0] last_m = merge({8'h00, last}, wb_dat_i, wb_sel_i);

  ptec_edge #(
    .W(1)
  ) u_trig (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(trig_pin_i),
    .inv_i(ctrl[`PTEC_CTRL_TPOL]),
    .level_o(trig_lvl),
    .rise_o(trig_rise)
  );

  ptec_edge #(
    .W(1)
  ) u_evt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(evt_pin_i),
    .inv_i(ctrl[`PTEC_CTRL_EPOL]),
    .level_o(),
    .rise_o(evt_rise)
  );

  // The port carries positive logic only.
  ptec_edge #(
    .W(`PTEC_PORT_W)
  ) u_port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(port_i),
    .inv_i({`PTEC_PORT_W{1'b0}}),
    .level_o(port_lvl),
    .rise_o(port_rise)
  );

  // While the shared pin drives the trigger pulse, the event path is
  // deaf, otherwise our own pulse would step the sequencer.
  wire evt_ok = evt_rise & ~tout_en & play_o;

  // Data and half-select are synchronised through the same depth as
  // load, so the values seen with the load edge are those set up
  // before it on the pins.
  wire load = port_rise[`PTEC_PIN_LOAD] & ~port_out;
  wire half = port_lvl[`PTEC_PIN_HALF];
  wire jump = load & half;

  // A count of zero is treated as one pass.
  wire rep_last = ({1'b0, rep_cnt} + 17'h1) >= {1'b0, rep_num};
  wire seg_done = seg_end_i & play_o & ~until_evt & rep_last;
  wire adv = play_o & (evt_ok | seg_done);
  wire wrap = index_o == last;
  wire once_end = adv & wrap & ext & (mode == `PTEC_MODE_TRIG);

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (run) begin
          if (mode == `PTEC_MODE_CONT) begin
            next_state = ST_PLAY;
          end else if (mode == `PTEC_MODE_GATE && ext) begin
            next_state = ST_GATE;
          end else begin
            next_state = ST_ARM;
          end
        end
      end
      ST_ARM: begin
        if (!run) begin
          next_state = ST_IDLE;
        end else if (trig_rise) begin
          next_state = ST_PLAY;
        end
      end
      ST_PLAY: begin
        if (!run) begin
          next_state = ST_IDLE;
        end else if (once_end) begin
          next_state = ST_ARM;
        end
      end
      ST_GATE: begin
        if (!run) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Playback of this block follows only its own trigger input.
  wire next_play = (next_state == ST_PLAY) |
                   ((next_state == ST_GATE) & trig_lvl);
  wire start = next_play & ~play_o;
  wire fire = tout_en & (start | adv | jump);

  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      play_o <= 1'b0;
    end else begin
      state <= next_state;
      play_o <= next_play;
    end
  end

  // Sequencer position and repeat counter.
  always @(posedge clk_i) begin
    if (rst_i) begin
      index_o <= {`PTEC_SEL_W{1'b0}};
      rep_cnt <= 16'h0000;
      step_o <= 1'b0;
    end else begin
      step_o <= adv | jump;
      if (jump) begin
        index_o <= {port_lvl[`PTEC_HALF_W-1:0], dlow};
        rep_cnt <= 16'h0000;
      end else if (adv) begin
        rep_cnt <= 16'h0000;
        if (wrap) begin
          index_o <= {`PTEC_SEL_W{1'b0}};
        end else begin
          index_o <= index_o + 24'h000001;
        end
      end else if (seg_end_i && play_o) begin
        if (!until_evt) begin
          rep_cnt <= rep_cnt + 16'h0001;
        end
      end else if (state != ST_IDLE && next_state == ST_IDLE) begin
        // Reset only on stop, so a selection loaded while idle survives.
        index_o <= {`PTEC_SEL_W{1'b0}};
        rep_cnt <= 16'h0000;
      end
    end
  end

  // Dynamic selection capture: low half first, high half completes.
  always @(posedge clk_i) begin
    if (rst_i) begin
      dlow <= {`PTEC_HALF_W{1'b0}};
      dsel <= {`PTEC_SEL_W{1'b0}};
      dnew <= 1'b0;
    end else begin
      if (load && !half) begin
        dlow <= port_lvl[`PTEC_HALF_W-1:0];
      end
      if (jump) begin
        dsel <= {port_lvl[`PTEC_HALF_W-1:0], dlow};
      end
      // A new value arriving with the clear keeps the flag set.
      if (jump) begin
        dnew <= 1'b1;
      end else if (wb_wr && wb_adr_i == `PTEC_ADR_STATUS &&
                   wb_sel_i[0] && wb_dat_i[`PTEC_STAT_DNEW]) begin
        dnew <= 1'b0;
      end
    end
  end

  // Trigger output pulse; a new cause restarts the full width.
  always @(posedge clk_i) begin
    if (rst_i) begin
      tcnt <= 11'h000;
      evt_pin_o <= 1'b0;
      evt_pin_oe_o <= 1'b0;
    end else begin
      evt_pin_oe_o <= tout_en;
      if (fire) begin
        tcnt <= `PTEC_TRIG_PULSE_CYC - 11'h001;
        evt_pin_o <= 1'b1;
      end else if (!tout_en) begin
        tcnt <= 11'h000;
        evt_pin_o <= 1'b0;
      end else if (tcnt != 11'h000) begin
        tcnt <= tcnt - 11'h001;
      end else begin
        evt_pin_o <= 1'b0;
      end
    end
  end

  // Parallel port direction and general purpose output lines.
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_o <= {`PTEC_PORT_W{1'b0}};
      port_oe_o <= {`PTEC_PORT_W{1'b0}};
    end else begin
      port_o <= gpo;
      port_oe_o <= {`PTEC_PORT_W{port_out}};
    end
  end

  // Register writes. Mode and polarity changes take effect at once, so
  // software should clear the run bit before changing the mode.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `PTEC_CTRL_RST;
      rep <= `PTEC_REP_RST;
      gpo <= {`PTEC_PORT_W{1'b0}};
      last <= {`PTEC_SEL_W{1'b0}};
    end else if (wb_wr) begin
      case (wb_adr_i)
        `PTEC_ADR_CTRL: begin
          ctrl <= merge(ctrl, wb_dat_i, wb_sel_i) & 32'h000000ff;
        end
        `PTEC_ADR_REPEAT: begin
          rep <= merge(rep, wb_dat_i, wb_sel_i) & 32'h8000ffff;
        end
        `PTEC_ADR_GPO: begin
          gpo <= gpo_m[`PTEC_PORT_W-1:0];
        end
        `PTEC_ADR_LAST: begin
          last <= last_m[`PTEC_SEL_W-1:0];
        end
        default: begin
          ctrl <= ctrl;
        end
      endcase
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always @* begin
    next_dat = 32'h00000000;
    case (wb_adr_i)
      `PTEC_ADR_CTRL: begin
        next_dat = ctrl;
      end
      `PTEC_ADR_STATUS: begin
        next_dat[`PTEC_STAT_DNEW] = dnew;
        next_dat[`PTEC_STAT_PLAY] = play_o;
        next_dat[`PTEC_STAT_TLVL] = trig_lvl;
        next_dat[`PTEC_STAT_TOUT] = evt_pin_o;
        next_dat[`PTEC_STAT_ST_LSB +: 4] = state;
      end
      `PTEC_ADR_REPEAT: begin
        next_dat = rep;
      end
      `PTEC_ADR_GPO: begin
        next_dat[`PTEC_PORT_W-1:0] = gpo;
      end
      `PTEC_ADR_DSEL: begin
        next_dat[`PTEC_SEL_W-1:0] = dsel;
      end
      `PTEC_ADR_INDEX: begin
        next_dat[`PTEC_SEL_W-1:0] = index_o;
      end
      `PTEC_ADR_LAST: begin
        next_dat[`PTEC_SEL_W-1:0] = last;
      end
      default: begin
        next_dat = 32'h00000000;
      end
    endcase
  end

  // Every access, mapped or not, is acknowledged one cycle after it is
  // seen, and ack drops in the cycle after.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= next_dat;
      end
    end
  end

endmodule // ptec_top

`default_nettype wire

/* tb/ptec_top_asserts.sv */
// Checker watching the ports of the trigger and event control block.
`timescale 1ns/10ps
`default_nettype none
`include "ptec_consts.vh"
module ptec_chk (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic evt_pin_o,
  input wire logic evt_pin_oe_o,
  input wire logic [`PTEC_PORT_W-1:0] port_oe_o,
  input wire logic play_o,
  input wire logic step_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  reg [15:0] hi_cnt;
  // Counts how long the trigger output has been high so far.
  always @(posedge clk_i) begin
    if (rst_i || !evt_pin_o)
      hi_cnt <= 16'h0000;
    else
      hi_cnt <= hi_cnt + 16'h0001;
  end
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_pin_shared: assert property (evt_pin_o |-> evt_pin_oe_o)
    else $error("pulse on undriven pin");
  a_pulse_full: assert property ($fell(evt_pin_o) && evt_pin_oe_o |->
    hi_cnt >= 16'd1280) else $error("trigger pulse short");
  a_step_single: assert property (step_o |=> !step_o)
    else $error("step longer than one cycle");
  a_port_dir: assert property (port_oe_o == 14'h0000 ||
    port_oe_o == 14'h3fff) else $error("port enables split");
  a_reset_idle: assert property ($fell(rst_i) |->
    !play_o && !evt_pin_oe_o && port_oe_o == 14'h0000)
    else $error("outputs busy after reset");
endmodule // ptec_chk
bind ptec_top ptec_chk ptec_chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .evt_pin_o, .evt_pin_oe_o, .port_oe_o, .play_o, .step_o);
`default_nettype wire

/* tb/ptec_far.sv */
// Far-side test hardware driving trigger, event, port and segment lines.
`timescale 1ns/10ps
`default_nettype none
module ptec_far (
  // Clock.
  input wire logic clk_i,
  // Lines towards the block.
  output logic trig_o,
  output logic evt_o,
  output logic seg_o,
  output logic [13:0] port_o
);
  initial begin
    trig_o = 1'b0;
    evt_o = 1'b0;
    seg_o = 1'b0;
    port_o = 14'h0000;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // A slow source: each level stays long enough for the toggle limit.
  task automatic set_trig(input logic v);
    @(posedge clk_i);
    trig_o <= v;
    hold(900);
  endtask
  task automatic pulse_evt(input logic a);
    @(posedge clk_i);
    evt_o <= a;
    hold(8);
    evt_o <= ~a;
    hold(8);
  endtask
  task automatic seg();
    @(posedge clk_i);
    seg_o <= 1'b1;
    @(posedge clk_i);
    seg_o <= 1'b0;
  endtask
  // Lines are scrambled after the load rise, so a late capture shows.
  task automatic load(input logic h, input logic [11:0] d);
    @(posedge clk_i);
    port_o <= {1'b0, h, d};
    hold(4);
    port_o[13] <= 1'b1;
    hold(4);
    port_o <= {1'b0, ~h, ~d};
    hold(10);
  endtask
endmodule // ptec_far
`default_nettype wire

/* tb/ptec_tb_top.sv */
// Self-checking bench for the trigger and event control block.
`timescale 1ns/10ps
`default_nettype none
module ptec_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, evt_pin_o, evt_pin_oe_o, play_o, step_o;
  wire trig_pin_i, evt_far, seg_end_i;
  wire [13:0] port_o, port_oe_o, port_i;
  wire [23:0] index_o;
  int bad_count = 0;
  int cmp_count = 0;
  int ex, n;
  int steps = 0;
  // Counts broadcast step pulses seen on the sequencer output.
  always @(posedge clk_i)
    if (step_o === 1'b1)
      steps++;
  logic [31:0] r, v;
  // The shared pin carries the trigger output whenever the block drives it.
  wire evt_pin_i = evt_pin_oe_o ? evt_pin_o : evt_far;
  always #50 clk_i = ~clk_i;
  ptec_top ptec_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .trig_pin_i,
    .evt_pin_i, .evt_pin_o, .evt_pin_oe_o, .port_i, .port_o, .port_oe_o,
    .seg_end_i, .play_o, .step_o, .index_o);
  ptec_far ptec_far_inst (.clk_i, .trig_o(trig_pin_i), .evt_o(evt_far),
    .seg_o(seg_end_i), .port_o(port_i));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] o,
                     input logic [31:0] e);
    cmp_count++;
    if (o !== e) begin
      bad_count++;
      $display("BAD %s exp %h saw %h", s, e, o);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= s;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      bad_count++;
      print_verdict();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffffffff);
    wb(1'b0, a, 32'h0);
    chk("reg", r & m, e);
  endtask
  initial begin
    #(100 * 60000);
    bad_count++;
    print_verdict();
  end
  initial begin
    r = $urandom(32'h1ab18f28);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(8'h00, 32'h0);
    rc(8'h08, 32'h1);
    rc(8'h0c, 32'h0);
    rc(8'h18, 32'h0);
    wb(1'b1, 8'h18, 32'h00ffffff, 4'h2);
    rc(8'h18, 32'h0000ff00);
    wb(1'b1, 8'h1c, 32'hffffffff);
    rc(8'h1c, 32'h0);
    v = $urandom & 32'h3fff;
    wb(1'b1, 8'h0c, v);
    wb(1'b1, 8'h00, 32'h40);
    repeat (3) @(posedge clk_i);
    chk("port", port_o, v);
    chk("oe", port_oe_o, 32'h3fff);
    rc(8'h0c, v);
    wb(1'b1, 8'h00, 32'h0);
    v = $urandom & 32'hffffff;
    ptec_far_inst.load(1'b0, v[11:0]);
    ptec_far_inst.load(1'b1, v[23:12]);
    chk("oe", port_oe_o, 32'h0);
    chk("index", index_o, v);
    rc(8'h10, v);
    rc(8'h04, 32'h1, 32'h1);
    wb(1'b1, 8'h04, 32'h1);
    rc(8'h04, 32'h0, 32'h1);
    for (int p = 0; p < 2; p++) begin
      ptec_far_inst.set_trig(p[0]);
      wb(1'b1, 8'h00, 32'h81 | (p << 3));
      repeat (8) @(posedge clk_i);
      chk("armed", play_o, 32'h0);
      ptec_far_inst.set_trig(!p[0]);
      chk("play", play_o, 32'h1);
      wb(1'b1, 8'h00, 32'h0);
    end
    wb(1'b1, 8'h18, 32'h3);
    wb(1'b1, 8'h08, 32'h80000000);
    ptec_far_inst.pulse_evt(1'b0);
    wb(1'b1, 8'h00, 32'h90);
    ex = 0;
    repeat (5) begin
      ptec_far_inst.pulse_evt(1'b0);
      ex = (ex == 3) ? 0 : ex + 1;
      chk("evt", index_o, ex);
    end
    chk("step", steps, 32'd6);
    ptec_far_inst.seg();
    repeat (4) @(posedge clk_i);
    chk("until", index_o, ex);
    wb(1'b1, 8'h08, 32'h2);
    ptec_far_inst.seg();
    repeat (4) @(posedge clk_i);
    chk("rep", index_o, ex);
    ptec_far_inst.seg();
    repeat (4) @(posedge clk_i);
    chk("rep", index_o, ex + 1);
    wb(1'b1, 8'h00, 32'hb0);
    ptec_far_inst.pulse_evt(1'b0);
    chk("shared", index_o, ex + 1);
    ptec_far_inst.seg();
    repeat (4) @(posedge clk_i);
    ptec_far_inst.seg();
    n = 0;
    repeat (2000) begin
      @(posedge clk_i);
      if (evt_pin_o === 1'b1)
        n++;
      else if (n > 0)
        break;
    end
    chk("width", n, 32'd1280);
    chk("pin", evt_pin_oe_o, 32'h1);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h00, 32'h86);
    repeat (8) @(posedge clk_i);
    chk("gate", play_o, 32'h0);
    ptec_far_inst.set_trig(1'b1);
    chk("gate", play_o, 32'h1);
    ptec_far_inst.set_trig(1'b0);
    chk("gate", play_o, 32'h0);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h08, 32'h1);
    wb(1'b1, 8'h18, 32'h0);
    wb(1'b1, 8'h00, 32'h85);
    ptec_far_inst.set_trig(1'b1);
    chk("once", play_o, 32'h1);
    ptec_far_inst.seg();
    repeat (4) @(posedge clk_i);
    chk("once", play_o, 32'h0);
    chk("once", index_o, 32'h0);
    print_verdict();
  end
endmodule // ptec_tb_top
`default_nettype wire
